// [design/bom_top.sv]
// bom_top: two-level battery overvoltage monitor with APB registers
// and a level interrupt.
// assumes battVolt is produced on ref_clk; ack and lock are pins.
//
// What this block does
// - two independent definite-time overvoltage levels
// - alarm after voltage at/above threshold for delay
// - threshold 8.0-42.0 V, defaults 32.0/35.0 V
// - delay 0.02-99.99 s, defaults 5.00/1.00 s
// - drop below threshold minus hysteresis resets timer
// - per-level enable, default on, off stops all
// - trip raises level alarm flag and indication
// - each level carries its own alarm class
// - self-acknowledge clears alarm when condition ends
// - otherwise alarm holds until manual/external acknowledge
// - lockable levels held idle, timer cleared, while monitoring lock true
//
// The APB register port and the register offsets were left to the implementer.
module bom_top
  import bom_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  // measurement and pins
  input  wire logic [VOLT_W-1:0] battVolt,
  input  wire logic              extAckPin,
  input  wire logic              monLockPin,
  // alarm outputs
  output logic      [1:0]        alarmFlag,
  output logic      [1:0][2:0]   alarmClass,
  output logic                   irq
);

  localparam int TW = $clog2(TICK_CYCLES_P + 1);

  bom_cfg_t [1:0]        cfg;
  bom_cfg_t [1:0]        next_cfg;
  bom_lvl_st_t [1:0]     lvlSt;
  logic [1:0]            manAck;
  logic [1:0]            next_manAck;
  logic [1:0]            ackPulse;
  logic [IRQ_W-1:0]      istat;
  logic [IRQ_W-1:0]      next_istat;
  logic [IRQ_W-1:0]      imask;
  logic [IRQ_W-1:0]      next_imask;
  logic [IRQ_W-1:0]      events;
  logic [1:0]            alarmPrev;
  logic                  next_pready;
  logic [31:0]           next_prdata;
  logic                  next_pslverr;
  logic                  next_irq;
  logic [TW-1:0]         tickCnt;
  logic [TW-1:0]         next_tickCnt;
  logic                  tick;
  logic                  next_tick;
  logic [1:0]            pinSync;
  logic                  extAckPrev;
  logic                  extAckRise;
  logic                  accessCyc;
  logic                  xfer;
  logic                  mapped;
  logic [31:0]           rdVal;
  logic [1:0]            wrCfg;
  logic [1:0]            wrDly;
  logic                  wrIstat;
  logic                  wrImask;
  logic                  wrAck;
  logic [1:0]            next_alarmPrev;
  logic                  next_extAckPrev;

  function automatic logic [VOLT_W-1:0] clampThr(input logic [31:0] w);
    logic [VOLT_W-1:0] v;
    v = w[CFG_THR_LSB +: VOLT_W];
    if (v < VOLT_MIN) begin
      clampThr = VOLT_MIN;
    end else if (v > VOLT_MAX) begin
      clampThr = VOLT_MAX;
    end else begin
      clampThr = v;
    end
  endfunction : clampThr

  function automatic logic [DLY_W-1:0] clampDly(input logic [31:0] w);
    logic [DLY_W-1:0] v;
    v = w[DLY_W-1:0];
    if (v < DLY_MIN) begin
      clampDly = DLY_MIN;
    end else if (v > DLY_MAX) begin
      clampDly = DLY_MAX;
    end else begin
      clampDly = v;
    end
  endfunction : clampDly

  function automatic logic [2:0] clampCls(input logic [31:0] w);
    logic [2:0] v;
    v = w[CFG_CLS_LSB +: 3];
    if (v > CLS_CONTROL) begin
      clampCls = CLS_CONTROL;
    end else begin
      clampCls = v;
    end
  endfunction : clampCls

  function automatic logic [31:0] cfgWord(input bom_cfg_t c);
    logic [31:0] w;
    w = '0;
    w[CFG_EN] = c.en;
    w[CFG_SACK] = c.selfAck;
    w[CFG_LOCK] = c.lockable;
    w[CFG_CLS_LSB +: 3] = c.cls;
    w[CFG_THR_LSB +: VOLT_W] = c.thr;
    cfgWord = w;
  endfunction : cfgWord

  // ack and lock pins are asynchronous
  bom_sync #(
    .W (2)
  ) u_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .din     ({monLockPin, extAckPin}),
    .dout    (pinSync)
  );

  assign extAckRise = pinSync[0] && !extAckPrev;

  // shared 10 ms time base for both delay timers
  always_comb begin
    if (tickCnt >= TW'(TICK_CYCLES_P - 1)) begin
      next_tickCnt = '0;
      next_tick    = 1'b1;
    end else begin
      next_tickCnt = TW'(tickCnt + 1'b1);
      next_tick    = 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_lvl
      assign ackPulse[gi] = manAck[gi] | extAckRise;
      bom_level u_level (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .cfg      (cfg[gi]),
        .volt     (battVolt),
        .tick     (tick),
        .lockOn   (pinSync[1]),
        .ackPulse (ackPulse[gi]),
        .st       (lvlSt[gi])
      );
      assign alarmFlag[gi] = lvlSt[gi].alarm;
      assign alarmClass[gi] = cfg[gi].cls;
      assign events[IRQ_RISE_LSB + gi] =
        lvlSt[gi].alarm && !alarmPrev[gi];
      assign events[IRQ_FALL_LSB + gi] =
        !lvlSt[gi].alarm && alarmPrev[gi];
    end
  endgenerate

  // apb: one wait state, answer registered
  assign accessCyc = psel && penable && !pready;
  assign xfer      = psel && penable && pready;

  always_comb begin
    mapped = 1'b1;
    rdVal  = '0;
    if (paddr == ADDR_CFG1) begin
      rdVal = cfgWord(cfg[0]);
    end else if (paddr == ADDR_CFG2) begin
      rdVal = cfgWord(cfg[1]);
    end else if (paddr == ADDR_DLY1) begin
      rdVal[DLY_W-1:0] = cfg[0].dly;
    end else if (paddr == ADDR_DLY2) begin
      rdVal[DLY_W-1:0] = cfg[1].dly;
    end else if (paddr == ADDR_STATUS) begin
      rdVal[ST_ALARM_LSB] = lvlSt[0].alarm;
      rdVal[ST_ALARM_LSB + 1] = lvlSt[1].alarm;
      rdVal[ST_TIMING_LSB] = lvlSt[0].timing;
      rdVal[ST_TIMING_LSB + 1] = lvlSt[1].timing;
      rdVal[ST_LOCK] = pinSync[1];
    end else if (paddr == ADDR_ISTAT) begin
      rdVal[IRQ_W-1:0] = istat;
    end else if (paddr == ADDR_IMASK) begin
      rdVal[IRQ_W-1:0] = imask;
    end else if (paddr == ADDR_ACK) begin
      rdVal = '0;
    end else begin
      mapped = 1'b0;
    end
  end

  always_comb begin
    next_pready  = accessCyc;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (accessCyc) begin
      next_prdata  = pwrite ? 32'h0000_0000 : rdVal;
      next_pslverr = !mapped;
    end
  end

  // write strobes: one per register except status, only on the completing edge
  always_comb begin
    wrCfg   = '0;
    wrDly   = '0;
    wrIstat = 1'b0;
    wrImask = 1'b0;
    wrAck   = 1'b0;
    if (xfer && pwrite) begin
      if (paddr == ADDR_CFG1) begin
        wrCfg[0] = 1'b1;
      end else if (paddr == ADDR_CFG2) begin
        wrCfg[1] = 1'b1;
      end else if (paddr == ADDR_DLY1) begin
        wrDly[0] = 1'b1;
      end else if (paddr == ADDR_DLY2) begin
        wrDly[1] = 1'b1;
      end else if (paddr == ADDR_ISTAT) begin
        wrIstat = 1'b1;
      end else if (paddr == ADDR_IMASK) begin
        wrImask = 1'b1;
      end else if (paddr == ADDR_ACK) begin
        wrAck = 1'b1;
      end
    end
  end

  // level two above level one is left to software
  always_comb begin
    next_cfg    = cfg;
    next_manAck = '0;
    for (int i = 0; i < 2; i++) begin
      if (wrCfg[i]) begin
        next_cfg[i].en       = pwdata[CFG_EN];
        next_cfg[i].selfAck  = pwdata[CFG_SACK];
        next_cfg[i].lockable = pwdata[CFG_LOCK];
        next_cfg[i].cls      = clampCls(pwdata);
        next_cfg[i].thr      = clampThr(pwdata);
      end
      if (wrDly[i]) begin
        next_cfg[i].dly = clampDly(pwdata);
      end
    end
    if (wrAck) begin
      next_manAck = pwdata[1:0];
    end
  end

  // a new event wins over a clear in the same cycle
  always_comb begin
    next_imask = imask;
    next_istat = istat;
    if (wrImask) begin
      next_imask = pwdata[IRQ_W-1:0];
    end
    if (wrIstat) begin
      next_istat = istat & ~pwdata[IRQ_W-1:0];
    end
    next_istat = next_istat | events;
    next_irq   = |(next_istat & next_imask);
  end

  // history resets to the idle pin level, so no false edge after reset
  always_comb begin
    next_alarmPrev  = alarmFlag;
    next_extAckPrev = pinSync[0];
  end

  // time base
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tickCnt <= '0;
      tick    <= 1'b0;
    end else begin
      tickCnt <= next_tickCnt;
      tick    <= next_tick;
    end
  end

  // apb answer
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= next_pready;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // settings and manual acknowledge
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg[0] <= '{en: 1'b1, selfAck: 1'b1, lockable: 1'b1,
                  cls: CLS_RST, thr: THR1_RST, dly: DLY1_RST};
      cfg[1] <= '{en: 1'b1, selfAck: 1'b1, lockable: 1'b1,
                  cls: CLS_RST, thr: THR2_RST, dly: DLY2_RST};
      manAck <= '0;
    end else begin
      cfg    <= next_cfg;
      manAck <= next_manAck;
    end
  end

  // interrupt state
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      imask <= '0;
      istat <= '0;
      irq   <= 1'b0;
    end else begin
      imask <= next_imask;
      istat <= next_istat;
      irq   <= next_irq;
    end
  end

  // edge history
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alarmPrev  <= '0;
      extAckPrev <= 1'b0;
    end else begin
      alarmPrev  <= next_alarmPrev;
      extAckPrev <= next_extAckPrev;
    end
  end

endmodule : bom_top

// [design/bom_pkg.sv]
// bom_pkg: constants, field layout and carrier types of the battery
// overvoltage monitor.
// assumes a 40 MHz ref_clk and voltages coded in steps of 0.1 V.
package bom_pkg;

  // clock and delay timer base
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_TIME_NS  = 10_000_000;
  localparam int TICK_CYCLES   =
    (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // voltage in units of 0.1 V, delay in units of 10 ms
  localparam int VOLT_W = 9;
  localparam int DLY_W  = 14;
  localparam logic [8:0]  VOLT_MIN = 9'h050;
  localparam logic [8:0]  VOLT_MAX = 9'h1a4;
  localparam logic [8:0]  HYST     = 9'h005;
  localparam logic [8:0]  THR1_RST = 9'h140;
  localparam logic [8:0]  THR2_RST = 9'h15e;
  localparam logic [13:0] DLY_MIN  = 14'h0002;
  localparam logic [13:0] DLY_MAX  = 14'h270f;
  localparam logic [13:0] DLY1_RST = 14'h01f4;
  localparam logic [13:0] DLY2_RST = 14'h0064;

  // alarm classes A..F then control
  localparam logic [2:0] CLS_A       = 3'h0;
  localparam logic [2:0] CLS_CONTROL = 3'h6;
  localparam logic [2:0] CLS_RST     = CLS_A;

  // register byte addresses
  localparam logic [7:0] ADDR_CFG1   = 8'h00;
  localparam logic [7:0] ADDR_CFG2   = 8'h04;
  localparam logic [7:0] ADDR_DLY1   = 8'h08;
  localparam logic [7:0] ADDR_DLY2   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_ISTAT  = 8'h14;
  localparam logic [7:0] ADDR_IMASK  = 8'h18;
  localparam logic [7:0] ADDR_ACK    = 8'h1c;

  // config register fields
  localparam int CFG_EN      = 0;
  localparam int CFG_SACK    = 1;
  localparam int CFG_LOCK    = 2;
  localparam int CFG_CLS_LSB = 4;
  localparam int CFG_THR_LSB = 16;

  // status register fields
  localparam int ST_ALARM_LSB  = 0;
  localparam int ST_TIMING_LSB = 2;
  localparam int ST_LOCK       = 4;

  // interrupt bits: alarm raised per level, alarm cleared per level
  localparam int IRQ_W        = 4;
  localparam int IRQ_RISE_LSB = 0;
  localparam int IRQ_FALL_LSB = 2;

  typedef struct packed {
    logic             en;
    logic             selfAck;
    logic             lockable;
    logic [2:0]       cls;
    logic [VOLT_W-1:0] thr;
    logic [DLY_W-1:0] dly;
  } bom_cfg_t;

  typedef struct packed {
    logic alarm;
    logic timing;
  } bom_lvl_st_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TIME = 3'b010,
    ST_TRIP = 3'b100
  } bom_state_t;

endpackage : bom_pkg

// [design/bom_sync.sv]
// bom_sync: two flip-flop synchroniser for asynchronous pins.
// assumes each bit is an independent level.
module bom_sync
  import bom_pkg::*;
#(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // pins and synchronised levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule : bom_sync

// [design/bom_level.sv]
// bom_level: one definite-time overvoltage level with delay timer
// and alarm latch.
// assumes tick is a one-cycle pulse every 10 ms and lockOn, ackPulse
// are already in the ref_clk domain.
module bom_level
  import bom_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // settings and measurement
  input  bom_cfg_t               cfg,
  input  wire logic [VOLT_W-1:0] volt,
  // timing and control
  input  wire logic              tick,
  input  wire logic              lockOn,
  input  wire logic              ackPulse,
  // state
  output bom_lvl_st_t            st
);

  bom_state_t        state;
  bom_state_t        next_state;
  logic [DLY_W-1:0]  cnt;
  logic [DLY_W-1:0]  next_cnt;
  logic              alarm;
  logic              next_alarm;
  logic              active;
  logic              over;
  logic              below;
  logic              setNow;
  logic [VOLT_W-1:0] relThr;
  logic [DLY_W-1:0]  cntInc;

  assign active = cfg.en && !(cfg.lockable && lockOn);
  assign over   = volt >= cfg.thr;
  assign relThr = (cfg.thr > HYST) ? cfg.thr - HYST : '0;
  assign below  = volt < relThr;
  assign cntInc = DLY_W'(cnt + 1'b1);

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_alarm = alarm;
    setNow     = 1'b0;
    if (!active) begin
      next_state = ST_IDLE;
      next_cnt   = '0;
      if (!cfg.en || cfg.selfAck) begin
        next_alarm = 1'b0;
      end
    end else begin
      case (state)
        ST_IDLE: begin
          if (over) begin
            next_state = ST_TIME;
            next_cnt   = '0;
          end
        end
        ST_TIME: begin
          if (below) begin
            next_state = ST_IDLE;
            next_cnt   = '0;
          end else if (tick) begin
            // first tick may come up to 10 ms early: shared prescaler
            if (cntInc >= cfg.dly) begin
              next_state = ST_TRIP;
              next_alarm = 1'b1;
              setNow     = 1'b1;
            end else begin
              next_cnt = cntInc;
            end
          end
        end
        ST_TRIP: begin
          if (below) begin
            next_state = ST_IDLE;
            next_cnt   = '0;
            if (cfg.selfAck) begin
              next_alarm = 1'b0;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_cnt   = '0;
        end
      endcase
    end
    // acknowledge only once the condition is gone; a new trip wins
    if (ackPulse && !setNow && next_state != ST_TRIP) begin
      next_alarm = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      cnt   <= '0;
      alarm <= 1'b0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      alarm <= next_alarm;
    end
  end

  assign st.alarm  = alarm;
  assign st.timing = state[1];

endmodule : bom_level

// [dv/bom_top_chk.sv]
// bom_top_chk: port-level assertions of the overvoltage monitor.
// assumes one ref_clk domain; bound into every bom_top.
module bom_top_chk
  import bom_pkg::*;
#(
  parameter int TICK_CYCLES_P = 4
) (
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              sys_rst,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  // measurement, pins, alarms
  input wire logic [VOLT_W-1:0] battVolt,
  input wire logic              extAckPin,
  input wire logic              monLockPin,
  input wire logic [1:0]        alarmFlag,
  input wire logic [1:0][2:0]   alarmClass,
  input wire logic              irq
);
  logic [15:0] hiCnt;
  logic [1:0]  flagPrev;
  logic [2:0]  evtSh;
  wire logic   wrDone = psel && penable && pready && pwrite;
  wire logic   hiNow  = battVolt >= VOLT_MIN - HYST;

  // counts cycles that could keep a delay timer running
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hiCnt    <= 16'h0000;
      flagPrev <= 2'h0;
      evtSh    <= 3'h0;
    end else begin
      hiCnt    <= !hiNow ? 16'h0000 : hiCnt + {15'h0000, ~&hiCnt};
      flagPrev <= alarmFlag;
      evtSh    <= {evtSh[1:0], (alarmFlag != flagPrev) || wrDone};
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_RDY_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_RDY_WAIT: assert property
    ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("apb wait state wrong");
  AST_ERR_RDY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_PRD_HOLD: assert property ($changed(prdata) |-> $past(psel))
    else $error("prdata changed outside an access");
  AST_CLS_RANGE: assert property
    (alarmClass[0] <= CLS_CONTROL && alarmClass[1] <= CLS_CONTROL)
    else $error("alarm class out of range");
  AST_CLS_WRITE: assert property
    ($changed(alarmClass) |-> $past(wrDone) || $past(wrDone, 2))
    else $error("alarm class changed without a write");
  AST_ALM_DELAY: assert property
    (|($rose(alarmFlag)) |-> hiCnt >= 16'(TICK_CYCLES_P))
    else $error("alarm raised before minimum delay");
  AST_IRQ_CAUSE: assert property
    ($rose(irq) |-> evtSh != 3'h0)
    else $error("irq rose without an event");

  COV_ALARM: cover property (|($rose(alarmFlag)));
  COV_SLVERR: cover property (pslverr);
  COV_IRQ: cover property ($rose(irq));
endmodule : bom_top_chk

bind bom_top bom_top_chk #(.TICK_CYCLES_P(TICK_CYCLES_P)) chk_u (
  .ref_clk    (ref_clk),    .sys_rst   (sys_rst),
  .psel       (psel),       .penable   (penable),
  .pwrite     (pwrite),     .paddr     (paddr),
  .pwdata     (pwdata),     .pready    (pready),
  .prdata     (prdata),     .pslverr   (pslverr),
  .battVolt   (battVolt),   .extAckPin (extAckPin),
  .monLockPin (monLockPin), .alarmFlag (alarmFlag),
  .alarmClass (alarmClass), .irq       (irq));

// [dv/bom_batt_model.sv]
// bom_batt_model: battery measurement and discrete pins at the far side.
// assumes its tasks are called from the bench between clock edges.
module bom_batt_model
  import bom_pkg::*;
(
  // clock
  input wire logic              ref_clk,
  // measurement and pins
  output logic     [VOLT_W-1:0] battVolt,
  output logic                  extAckPin,
  output logic                  monLockPin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    battVolt   = 9'h0fa;
    extAckPin  = 1'b0;
    monLockPin = 1'b0;
  end

  task set_v(input logic [VOLT_W-1:0] v);
    @(posedge ref_clk);
    battVolt <= v;
  endtask : set_v

  // pulse long enough to pass the two-flop synchroniser
  task ack();
    @(posedge ref_clk);
    extAckPin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    extAckPin <= 1'b0;
  endtask : ack

  task lock(input logic l);
    @(posedge ref_clk);
    monLockPin <= l;
  endtask : lock
endmodule : bom_batt_model

// [dv/tb.sv]
// tb: register-level tests of the two-level overvoltage monitor.
// assumes a shortened 10 ms tick of four clocks.
module tb
  import bom_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

  logic              ref_clk, sys_rst, psel, penable, pwrite;
  logic              pready, pslverr, irq, extAckPin, monLockPin, errv;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rdv;
  logic [VOLT_W-1:0] battVolt;
  logic [1:0]        alarmFlag;
  logic [1:0][2:0]   alarmClass;
  int                n_errors, n_compared;

  bom_top #(.TICK_CYCLES_P(4)) dut_u (
    .ref_clk    (ref_clk),    .sys_rst   (sys_rst),
    .psel       (psel),       .penable   (penable),
    .pwrite     (pwrite),     .paddr     (paddr),
    .pwdata     (pwdata),     .pready    (pready),
    .prdata     (prdata),     .pslverr   (pslverr),
    .battVolt   (battVolt),   .extAckPin (extAckPin),
    .monLockPin (monLockPin), .alarmFlag (alarmFlag),
    .alarmClass (alarmClass), .irq       (irq));
  bom_batt_model model_u (
    .ref_clk    (ref_clk),    .battVolt   (battVolt),
    .extAckPin  (extAckPin),  .monLockPin (monLockPin));

  always #12.5 ref_clk = ~ref_clk;

  task end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      end_sim();
    end
    rdv  = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdv, e)
  endtask : rd

  task wait_flag(input logic [1:0] e);
    int n;
    n = 0;
    while (alarmFlag !== e && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    `CHK(alarmFlag, e)
    if (n == 200) end_sim();
  endtask : wait_flag

  task hold(input int c, input logic [1:0] e);
    repeat (c) @(posedge ref_clk);
    `CHK(alarmFlag, e)
  endtask : hold

  initial begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    n_errors = 0;
    n_compared = 0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(ADDR_CFG1, 32'h0140_0007);
    rd(ADDR_CFG2, 32'h015e_0007);
    rd(ADDR_DLY1, 32'h0000_01f4);
    rd(ADDR_DLY2, 32'h0000_0064);
    rd(8'h20, 32'h0);
    `CHK(errv, 1'b1)
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CFG2, 32'h015e_0007 | (32'(c) << 4));
      repeat (2) @(posedge ref_clk);
      `CHK(alarmClass[1], c > 6 ? CLS_CONTROL : 3'(c))
      `CHK(alarmClass[0], CLS_A)
    end
    wr(ADDR_CFG2, 32'h015e_0007);
    wr(ADDR_DLY1, 32'h3);
    wr(ADDR_DLY2, 32'h2);
    wr(ADDR_IMASK, 32'h1);
    $display("test class done");
    model_u.set_v(9'h14a);
    wait_flag(2'b01);
    hold(2, 2'b01);
    `CHK(irq, 1'b1)
    rd(ADDR_ISTAT, 32'h1);
    wr(ADDR_IMASK, 32'h0);
    hold(2, 2'b01);
    `CHK(irq, 1'b0)
    wr(ADDR_ISTAT, 32'h1);
    wr(ADDR_IMASK, 32'hf);
    model_u.set_v(9'h13c);
    hold(20, 2'b01);
    `CHK(irq, 1'b0)
    model_u.set_v(9'h12c);
    wait_flag(2'b00);
    hold(2, 2'b00);
    `CHK(irq, 1'b1)
    wr(ADDR_ISTAT, 32'hf);
    hold(2, 2'b00);
    `CHK(irq, 1'b0)
    $display("test trip done");
    // two short excursions that only together outlast the delay
    model_u.set_v(9'h14a);
    repeat (7) @(posedge ref_clk);
    model_u.set_v(9'h12c);
    repeat (3) @(posedge ref_clk);
    model_u.set_v(9'h14a);
    hold(7, 2'b00);
    model_u.set_v(9'h12c);
    hold(4, 2'b00);
    $display("test restart done");
    wr(ADDR_CFG1, 32'h0140_0005);
    model_u.set_v(9'h14a);
    wait_flag(2'b01);
    model_u.ack();
    hold(6, 2'b01);
    model_u.set_v(9'h12c);
    hold(20, 2'b01);
    model_u.ack();
    hold(6, 2'b00);
    model_u.set_v(9'h14a);
    wait_flag(2'b01);
    model_u.set_v(9'h12c);
    wr(ADDR_ACK, 32'h1);
    hold(3, 2'b00);
    wr(ADDR_CFG1, 32'h0140_0006);
    $display("test ack done");
    model_u.set_v(9'h168);
    wait_flag(2'b10);
    hold(30, 2'b10);
    model_u.set_v(9'h12c);
    wait_flag(2'b00);
    wr(ADDR_CFG1, 32'h0140_0007);
    model_u.lock(1'b1);
    wr(ADDR_CFG2, 32'h0136_0003);
    model_u.set_v(9'h168);
    wait_flag(2'b10);
    rd(ADDR_STATUS, 32'h0000_0012);
    hold(30, 2'b10);
    model_u.set_v(9'h12c);
    wait_flag(2'b00);
    $display("test enable lock done");
    end_sim();
  end
endmodule : tb
